// ===== mac_book_pkg.sv
package mac_book_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_EVENT    = 8'h00;
  localparam logic [7:0] OFS_TX_START = 8'h04;
  localparam logic [7:0] OFS_RX_START = 8'h08;
  localparam logic [7:0] OFS_RX_END   = 8'h0c;
  localparam logic [7:0] OFS_BUF_SIZE = 8'h10;
  localparam logic [7:0] OFS_MAX_FRM  = 8'h14;
  localparam logic [7:0] OFS_COL_WIN  = 8'h18;
  localparam logic [7:0] OFS_RETRY    = 8'h1c;
  localparam logic [7:0] OFS_CTRL     = 8'h20;
  localparam logic [7:0] OFS_TX_STAT  = 8'h24;
  localparam logic [7:0] OFS_RX_PTR   = 8'h28;

  // Event status bit positions
  localparam int EV_TX_DONE  = 0;
  localparam int EV_TX_CF    = 1;
  localparam int EV_RX_OVR   = 2;
  localparam int EV_RX_DONE  = 3;
  localparam int EV_RX_PCF   = 4;
  localparam int EV_RX_CF    = 5;
  localparam int EV_MGMT     = 6;
  localparam int EV_TX_FAULT = 7;

  // Transmit status word bit positions
  localparam int TS_OWNER = 15;
  localparam int TS_ABORT = 14;
  localparam int TS_BPA   = 13;
  localparam int TS_HUGE  = 12;
  localparam int TS_LOOR  = 11;
  localparam int TS_LCERR = 10;
  localparam int TS_FCS   = 9;
  localparam int TS_DEFER = 8;
  localparam int TS_XSDFR = 7;
  localparam int TS_UNDER = 6;
  localparam int TS_LATE  = 5;
  localparam int TS_MAXC  = 4;

  // Buffer size field and control bits
  localparam int BS_SEL_LSB = 6;
  localparam int CTRL_FCS   = 0;
  localparam int CTRL_TXRST = 1;

  // Reset values
  localparam logic [7:0]  BUF_SIZE_RST = 8'h00;
  localparam logic [15:0] MAX_FRM_RST  = 16'h05ee;
  localparam logic [5:0]  COL_WIN_RST  = 6'h38;
  localparam logic [3:0]  RETRY_RST    = 4'hf;
  localparam logic [1:0]  CTRL_RST     = 2'h1;

  // Frame and descriptor figures
  localparam logic [15:0] LEN_MAX       = 16'd1518;
  localparam logic [23:0] DESC_BYTES    = 24'd7;
  localparam logic [14:0] XS_DFR_NIBBLE = 15'd6071;
  localparam logic [14:0] XS_DFR_BIT    = 15'd24287;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } tx_state_t;
endpackage

// ===== desc_calc_if.sv
`timescale 1ns/1ns
interface desc_calc_if;
  logic [23:0] cur_ptr;
  logic [23:0] region_lo;
  logic [23:0] region_hi;
  logic [15:0] pkt_len;
  logic [1:0]  size_sel;
  logic [23:0] next_ptr;

  modport calc (input cur_ptr, region_lo, region_hi, pkt_len, size_sel, output next_ptr);
  modport user (output cur_ptr, region_lo, region_hi, pkt_len, size_sel, input next_ptr);
endinterface

// ===== desc_next_calc.sv
`timescale 1ns/1ns
module desc_next_calc
  import mac_book_pkg::*;
(
  desc_calc_if.calc c
);
  logic [23:0] mask;
  logic [23:0] span;
  logic [23:0] raw;

  // Descriptor plus frame, rounded up to whole packet buffers, wrapped in region
  always_comb begin
    mask = (24'd256 >> c.size_sel) - 24'd1;
    span = (DESC_BYTES + {8'h00, c.pkt_len} + mask) & ~mask;
    raw  = c.cur_ptr + span;
    if (raw >= c.region_hi) begin
      c.next_ptr = c.region_lo + (raw - c.region_hi);
    end else begin
      c.next_ptr = raw;
    end
  end
endmodule // desc_next_calc

// ===== mac_book.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// Overview of operation
// - Transmit engine fault sets event bit 7; software then resets the transmitter.
// - Management transaction with the PHY sets event bit 6.
// - Receive overrun sets event bit 2; packets discarded until software clears it.
// - Control frame transmission complete sets event bit 1.
// - Packet transmission complete sets event bit 0.
// - Control frame reception complete sets event bit 5.
// - Pause frame reception sets bit 4; any reception sets bit 3.
// - Three pointers split memory into transmit and receive regions.
// - Packet buffers of 32, 64, 128 or 256 bytes chosen by bits 7:6.
// - A packet may span several consecutive packet buffers.
// - Each packet starts with descriptor: next pointer, size, status; frame follows.
// - Next pointer is a 24-bit address of the following descriptor.
// - Size counts frame bytes with FCS, excluding the seven descriptor bytes.
// - Status bit 15 is ownership: 0 host, 1 MAC.
// - Status bits 14 abort, 13 back pressure, 12 size above max frame.
// - Bit 11 type/length above 1518; bit 10 length disagrees with data.
// - Bit 9 bad FCS when automatic FCS generation is disabled.
// - Bit 8 deferred; bit 7 deferral beyond 6071 nibble or 24287 bit times.
// - Bit 6 FIFO underrun; abort bit tells abandoned or retried.
// - Bit 5 late collision beyond window count; earlier collisions are retried.
// - Bit 4 and abort when collisions exceed the retry limit.
// - Bits 3:0 count collisions seen while sending the packet.
// - Written status clears ownership, returning the descriptor to the host.
module mac_book
  import mac_book_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_start,
  input  wire logic [23:0] tx_desc_np,
  input  wire logic [15:0] tx_desc_size,
  input  wire logic        tx_deferring,
  input  wire logic        tx_defer_tick,
  input  wire logic        speed_100,
  input  wire logic        tx_backpressure,
  input  wire logic        tx_collision,
  input  wire logic [15:0] tx_byte_cnt,
  input  wire logic        tx_underflow,
  input  wire logic        tx_underflow_retry,
  input  wire logic        tx_end,
  input  wire logic [15:0] tx_type_len,
  input  wire logic [15:0] tx_data_len,
  input  wire logic        tx_fcs_good,
  input  wire logic        tx_ctrl_frame,
  input  wire logic        tx_fault,
  input  wire logic        mgmt_done,
  input  wire logic        rx_end,
  input  wire logic [15:0] rx_len,
  input  wire logic        rx_ctrl,
  input  wire logic        rx_pause,
  input  wire logic        rx_overrun,
  output logic             tx_retry,
  output logic             tx_abort,
  output logic             tx_stat_wr,
  output logic      [15:0] tx_stat_word,
  output logic      [23:0] tx_next_ptr,
  output logic             tx_reset,
  output logic             auto_fcs_enable,
  output logic             rx_discard,
  output logic             rx_desc_wr,
  output logic      [23:0] rx_desc_addr,
  output logic      [23:0] rx_desc_np,
  output logic      [15:0] rx_desc_size,
  output logic             irq
);
  logic [7:0]  ev_q;
  logic [7:0]  ev_set;
  logic [23:0] tx_start_ptr_q;
  logic [23:0] rx_start_ptr_q;
  logic [23:0] rx_end_ptr_q;
  logic [7:0]  buf_size_q;
  logic [15:0] max_frm_q;
  logic [5:0]  col_win_q;
  logic [3:0]  retry_q;
  logic [1:0]  ctrl_q;
  logic [23:0] rx_ptr_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        wr_en;
  logic        rd_hit;
  logic [31:0] rd_val;
  tx_state_t   tx_state_q;
  logic [3:0]  coll_q;
  logic [14:0] dfr_cnt_q;
  logic        dfr_q;
  logic        xsdfr_q;
  logic        bpa_q;
  logic        busy;
  logic        late;
  logic        maxc;
  logic        under_abort;
  logic        abort_now;
  logic        retry_now;
  logic        finish;
  logic [4:0]  coll_inc;
  logic [14:0] dfr_lim;
  logic [15:0] stat_d;
  logic        rx_take;
  logic        tx_retry_q;
  logic        tx_abort_q;
  logic        tx_stat_wr_q;
  logic [15:0] tx_stat_q;
  logic [23:0] tx_next_q;
  logic        rx_desc_wr_q;
  logic [23:0] rx_desc_addr_q;
  logic [23:0] rx_desc_np_q;
  logic [15:0] rx_desc_size_q;
  logic        irq_q;

  desc_calc_if calc_bus ();

  desc_next_calc u_calc (
    .c (calc_bus.calc)
  );

  // Receive next-descriptor address from current slot and length
  assign calc_bus.cur_ptr   = rx_ptr_q;
  assign calc_bus.region_lo = rx_start_ptr_q;
  assign calc_bus.region_hi = rx_end_ptr_q;
  assign calc_bus.pkt_len   = rx_len;
  assign calc_bus.size_sel  = buf_size_q[BS_SEL_LSB +: 2];

  // APB: answer one cycle after setup, write lands at the access edge
  assign wr_en = psel & penable & pready_q & pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      OFS_EVENT:    rd_val = {24'h000000, ev_q};
      OFS_TX_START: rd_val = {8'h00, tx_start_ptr_q};
      OFS_RX_START: rd_val = {8'h00, rx_start_ptr_q};
      OFS_RX_END:   rd_val = {8'h00, rx_end_ptr_q};
      OFS_BUF_SIZE: rd_val = {24'h000000, buf_size_q};
      OFS_MAX_FRM:  rd_val = {16'h0000, max_frm_q};
      OFS_COL_WIN:  rd_val = {26'h0000000, col_win_q};
      OFS_RETRY:    rd_val = {28'h0000000, retry_q};
      OFS_CTRL:     rd_val = {30'h00000000, ctrl_q};
      OFS_TX_STAT:  rd_val = {16'h0000, tx_stat_q};
      OFS_RX_PTR:   rd_val = {8'h00, rx_ptr_q};
      default:      rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~rd_hit;
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_start_ptr_q <= 24'h000000;
      rx_start_ptr_q <= 24'h000000;
      rx_end_ptr_q   <= 24'h000000;
      buf_size_q     <= BUF_SIZE_RST;
      max_frm_q      <= MAX_FRM_RST;
      col_win_q      <= COL_WIN_RST;
      retry_q        <= RETRY_RST;
      ctrl_q         <= CTRL_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_TX_START: tx_start_ptr_q <= pwdata[23:0];
        OFS_RX_START: rx_start_ptr_q <= pwdata[23:0];
        OFS_RX_END:   rx_end_ptr_q   <= pwdata[23:0];
        OFS_BUF_SIZE: buf_size_q     <= pwdata[7:0];
        OFS_MAX_FRM:  max_frm_q      <= pwdata[15:0];
        OFS_COL_WIN:  col_win_q      <= pwdata[5:0];
        OFS_RETRY:    retry_q        <= pwdata[3:0];
        OFS_CTRL:     ctrl_q         <= pwdata[1:0];
        default:      ;
      endcase
    end
  end

  // Event sources; a set in the clearing cycle wins
  assign rx_take = rx_end & ~ev_q[EV_RX_OVR];

  always_comb begin
    ev_set = 8'h00;
    ev_set[EV_TX_FAULT] = tx_fault;
    ev_set[EV_MGMT]     = mgmt_done;
    ev_set[EV_RX_CF]    = rx_take & rx_ctrl;
    ev_set[EV_RX_PCF]   = rx_take & rx_pause;
    ev_set[EV_RX_DONE]  = rx_take;
    ev_set[EV_RX_OVR]   = rx_overrun;
    ev_set[EV_TX_CF]    = finish & tx_ctrl_frame;
    ev_set[EV_TX_DONE]  = finish;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q <= 8'h00;
    end else if (wr_en && paddr == OFS_EVENT) begin
      ev_q <= (ev_q & ~pwdata[7:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev_q | ev_set);
    end
  end

  // Transmit bookkeeping
  assign busy        = tx_state_q == TX_BUSY;
  assign coll_inc    = {1'b0, coll_q} + 5'd1;
  assign late        = tx_collision & (tx_byte_cnt > {10'h000, col_win_q});
  assign maxc        = tx_collision & ~late & (coll_inc > {1'b0, retry_q});
  assign under_abort = tx_underflow & ~tx_underflow_retry;
  assign abort_now   = busy & (late | maxc | under_abort);
  assign retry_now   = busy & ((tx_collision & ~late & ~maxc) | (tx_underflow & tx_underflow_retry));
  assign finish      = busy & (tx_end | abort_now) & ~ctrl_q[CTRL_TXRST];
  assign dfr_lim     = speed_100 ? XS_DFR_NIBBLE : XS_DFR_BIT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= TX_IDLE;
    end else if (ctrl_q[CTRL_TXRST]) begin
      tx_state_q <= TX_IDLE;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: if (tx_start) tx_state_q <= TX_BUSY;
        TX_BUSY: if (finish) tx_state_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_q <= 4'h0;
    end else if (tx_start && !busy) begin
      coll_q <= 4'h0;
    end else if (busy && tx_collision && coll_q != 4'hf) begin
      coll_q <= coll_inc[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dfr_cnt_q <= 15'h0000;
      dfr_q     <= 1'b0;
      xsdfr_q   <= 1'b0;
      bpa_q     <= 1'b0;
    end else if (tx_start && !busy) begin
      dfr_cnt_q <= 15'h0000;
      dfr_q     <= 1'b0;
      xsdfr_q   <= 1'b0;
      bpa_q     <= 1'b0;
    end else if (busy) begin
      if (tx_deferring) begin
        dfr_q <= 1'b1;
      end
      if (tx_deferring && tx_defer_tick && !xsdfr_q) begin
        dfr_cnt_q <= dfr_cnt_q + 15'd1;
        xsdfr_q   <= dfr_cnt_q >= dfr_lim;
      end
      if (tx_backpressure) begin
        bpa_q <= 1'b1;
      end
    end
  end

  always_comb begin
    stat_d = 16'h0000;
    stat_d[TS_OWNER] = 1'b0;
    stat_d[TS_ABORT] = abort_now;
    stat_d[TS_BPA]   = bpa_q | tx_backpressure;
    stat_d[TS_HUGE]  = tx_desc_size > max_frm_q;
    stat_d[TS_LOOR]  = tx_type_len > LEN_MAX;
    stat_d[TS_LCERR] = (tx_type_len <= LEN_MAX) & (tx_type_len != tx_data_len);
    stat_d[TS_FCS]   = ~ctrl_q[CTRL_FCS] & ~tx_fcs_good;
    stat_d[TS_DEFER] = dfr_q;
    stat_d[TS_XSDFR] = xsdfr_q;
    stat_d[TS_UNDER] = tx_underflow;
    stat_d[TS_LATE]  = late;
    stat_d[TS_MAXC]  = maxc;
    stat_d[3:0]      = (busy && tx_collision && coll_q != 4'hf) ? coll_inc[3:0] : coll_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_retry_q   <= 1'b0;
      tx_abort_q   <= 1'b0;
      tx_stat_wr_q <= 1'b0;
      tx_stat_q    <= 16'h0000;
      tx_next_q    <= 24'h000000;
    end else begin
      tx_retry_q   <= retry_now & ~ctrl_q[CTRL_TXRST];
      tx_abort_q   <= abort_now & ~ctrl_q[CTRL_TXRST];
      tx_stat_wr_q <= finish;
      if (finish) begin
        tx_stat_q <= stat_d;
        tx_next_q <= tx_desc_np;
      end else if (ctrl_q[CTRL_TXRST]) begin
        tx_next_q <= tx_start_ptr_q;
      end
    end
  end

  // Receive descriptor writer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ptr_q       <= 24'h000000;
      rx_desc_wr_q   <= 1'b0;
      rx_desc_addr_q <= 24'h000000;
      rx_desc_np_q   <= 24'h000000;
      rx_desc_size_q <= 16'h0000;
    end else begin
      rx_desc_wr_q <= rx_take;
      if (wr_en && paddr == OFS_RX_START) begin
        rx_ptr_q <= pwdata[23:0];
      end else if (rx_take) begin
        rx_ptr_q       <= calc_bus.next_ptr;
        rx_desc_addr_q <= rx_ptr_q;
        rx_desc_np_q   <= calc_bus.next_ptr;
        rx_desc_size_q <= rx_len;
      end
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign tx_retry        = tx_retry_q;
  assign tx_abort        = tx_abort_q;
  assign tx_stat_wr      = tx_stat_wr_q;
  assign tx_stat_word    = tx_stat_q;
  assign tx_next_ptr     = tx_next_q;
  assign tx_reset        = ctrl_q[CTRL_TXRST];
  assign auto_fcs_enable = ctrl_q[CTRL_FCS];
  assign rx_discard      = ev_q[EV_RX_OVR];
  assign rx_desc_wr      = rx_desc_wr_q;
  assign rx_desc_addr    = rx_desc_addr_q;
  assign rx_desc_np      = rx_desc_np_q;
  assign rx_desc_size    = rx_desc_size_q;
  assign irq             = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fault_flag;
    tx_fault |=> ev_q[EV_TX_FAULT] && irq;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault flag not set");

  property p_mgmt_flag;
    mgmt_done |=> ev_q[EV_MGMT];
  endproperty
  a_mgmt_flag: assert property (p_mgmt_flag) else $error("mgmt flag not set");

  property p_overrun_drop;
    rx_discard && rx_end |=> !rx_desc_wr && $stable(rx_ptr_q);
  endproperty
  a_overrun_drop: assert property (p_overrun_drop) else $error("packet kept during overrun");

  property p_tx_done;
    finish |=> tx_stat_wr ##1 !tx_stat_wr || busy;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done sequence wrong");

  property p_tx_done_flag;
    tx_stat_wr |-> ev_q[EV_TX_DONE];
  endproperty
  a_tx_done_flag: assert property (p_tx_done_flag) else $error("tx done flag missing");

  property p_owner_back;
    tx_stat_wr |-> !tx_stat_word[TS_OWNER];
  endproperty
  a_owner_back: assert property (p_owner_back) else $error("owner not returned");

  property p_maxc_abort;
    tx_stat_wr && tx_stat_word[TS_MAXC] |-> tx_stat_word[TS_ABORT] && tx_abort;
  endproperty
  a_maxc_abort: assert property (p_maxc_abort) else $error("max collisions not aborted");

  property p_rx_pause;
    rx_take && rx_pause |=> ev_q[EV_RX_PCF] && ev_q[EV_RX_DONE] && rx_desc_wr;
  endproperty
  a_rx_pause: assert property (p_rx_pause) else $error("pause reception not flagged");

  property p_rx_region;
    rx_desc_wr |-> rx_desc_np >= rx_start_ptr_q && rx_desc_np < rx_end_ptr_q;
  endproperty
  a_rx_region: assert property (p_rx_region) else $error("next pointer outside region");
endmodule // mac_book

// ===== host_model.sv
`timescale 1ns/1ns
module host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Request held until pready is seen high at a rising edge; answer taken at that edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule // host_model

// ===== mac_book_test.sv
`timescale 1ns/1ns
module mac_book_test
  import mac_book_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        tx_start = 1'b0, tx_deferring = 1'b0, tx_defer_tick = 1'b0, speed_100 = 1'b1;
  logic        tx_backpressure = 1'b0, tx_collision = 1'b0, tx_underflow = 1'b0, tx_underflow_retry = 1'b0;
  logic        tx_end = 1'b0, tx_fcs_good = 1'b1, tx_ctrl_frame = 1'b0, tx_fault = 1'b0, mgmt_done = 1'b0;
  logic        rx_end = 1'b0, rx_ctrl = 1'b0, rx_pause = 1'b0, rx_overrun = 1'b0;
  logic [23:0] tx_desc_np = 24'h0;
  logic [15:0] tx_desc_size = 16'h0, tx_byte_cnt = 16'h0, tx_type_len = 16'h0, tx_data_len = 16'h0;
  logic [15:0] rx_len = 16'h0;
  logic        tx_retry, tx_abort, tx_stat_wr, tx_reset, auto_fcs_enable, rx_discard, rx_desc_wr, irq;
  logic [15:0] tx_stat_word, rx_desc_size;
  logic [23:0] tx_next_ptr, rx_desc_addr, rx_desc_np;
  int          n_mismatch = 0, checks_done = 0;

  mac_book dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .tx_start, .tx_desc_np, .tx_desc_size, .tx_deferring, .tx_defer_tick, .speed_100, .tx_backpressure,
    .tx_collision, .tx_byte_cnt, .tx_underflow, .tx_underflow_retry, .tx_end, .tx_type_len, .tx_data_len,
    .tx_fcs_good, .tx_ctrl_frame, .tx_fault, .mgmt_done, .rx_end, .rx_len, .rx_ctrl, .rx_pause, .rx_overrun,
    .tx_retry, .tx_abort, .tx_stat_wr, .tx_stat_word, .tx_next_ptr, .tx_reset, .auto_fcs_enable, .rx_discard,
    .rx_desc_wr, .rx_desc_addr, .rx_desc_np, .rx_desc_size, .irq);

  host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask

  task automatic t_reset();
    logic [7:0]  a [6] = '{OFS_EVENT, OFS_BUF_SIZE, OFS_MAX_FRM, OFS_COL_WIN, OFS_RETRY, OFS_CTRL};
    logic [31:0] v [6] = '{32'h0, 32'h0, 32'h5ee, 32'h38, 32'hf, 32'h1};
    logic [31:0] r;
    logic        e;
    foreach (a[i]) rdc("reset_value", a[i], v[i]);
    chk("irq", 32'h0, {31'h0, irq});
    host.xfer(1'b0, 8'h3c, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    wr(OFS_MAX_FRM, 32'hffff05ee);
    rdc("max_frame", OFS_MAX_FRM, 32'h5ee);
    $display("t_reset done");
  endtask

  task automatic t_events();
    @(posedge pclk);
    mgmt_done <= 1'b1;
    tx_fault <= 1'b1;
    rx_overrun <= 1'b1;
    @(posedge pclk);
    mgmt_done <= 1'b0;
    tx_fault <= 1'b0;
    rx_overrun <= 1'b0;
    @(posedge pclk);
    rx_end <= 1'b1;
    rx_len <= 16'd60;
    #1 chk("irq", 32'h1, {31'h0, irq});
    chk("rx_discard", 32'h1, {31'h0, rx_discard});
    @(posedge pclk);
    rx_end <= 1'b0;
    #1 chk("rx_desc_wr", 32'h0, {31'h0, rx_desc_wr});
    rdc("event", OFS_EVENT, 32'hc4);
    wr(OFS_CTRL, 32'h3);
    #1 chk("tx_reset", 32'h1, {31'h0, tx_reset});
    wr(OFS_CTRL, 32'h1);
    wr(OFS_EVENT, 32'hc4);
    rdc("event", OFS_EVENT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    chk("rx_discard", 32'h0, {31'h0, rx_discard});
    $display("t_events done");
  endtask

  task automatic t_rx();
    wr(OFS_RX_END, 32'h1000);
    wr(OFS_BUF_SIZE, 32'hc0);
    wr(OFS_RX_START, 32'h100);
    @(posedge pclk);
    rx_end <= 1'b1;
    rx_len <= 16'd60;
    rx_pause <= 1'b1;
    rx_ctrl <= 1'b1;
    @(posedge pclk);
    rx_len <= 16'd26;
    rx_pause <= 1'b0;
    rx_ctrl <= 1'b0;
    #1 chk("rx_desc_wr", 32'h1, {31'h0, rx_desc_wr});
    chk("rx_desc_addr", 32'h100, {8'h0, rx_desc_addr});
    chk("rx_desc_np", 32'h100 + (7 + 60 + 31) / 32 * 32, {8'h0, rx_desc_np});
    chk("rx_desc_size", 32'd60, {16'h0, rx_desc_size});
    @(posedge pclk);
    rx_end <= 1'b0;
    #1 chk("rx_desc_addr", 32'h160, {8'h0, rx_desc_addr});
    chk("rx_desc_np", 32'h160 + (7 + 26 + 31) / 32 * 32, {8'h0, rx_desc_np});
    rdc("event", OFS_EVENT, 32'h38);
    wr(OFS_EVENT, 32'hff);
    $display("t_rx done");
  endtask

  task automatic t_tx();
    @(posedge pclk);
    tx_desc_np <= 24'h000440;
    tx_desc_size <= 16'd64;
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    repeat (2) begin
      @(posedge pclk);
      tx_collision <= 1'b1;
      tx_byte_cnt <= 16'h0010;
      tx_backpressure <= 1'b1;
      @(posedge pclk);
      tx_collision <= 1'b0;
      tx_backpressure <= 1'b0;
      #1 chk("tx_retry", 32'h1, {31'h0, tx_retry});
    end
    @(posedge pclk);
    tx_end <= 1'b1;
    tx_ctrl_frame <= 1'b1;
    tx_type_len <= 16'd46;
    tx_data_len <= 16'd46;
    @(posedge pclk);
    tx_end <= 1'b0;
    tx_ctrl_frame <= 1'b0;
    #1 chk("tx_stat_wr", 32'h1, {31'h0, tx_stat_wr});
    chk("tx_stat_word", 32'h2002, {16'h0, tx_stat_word});
    chk("tx_next_ptr", 32'h440, {8'h0, tx_next_ptr});
    rdc("tx_status", OFS_TX_STAT, 32'h2002);
    rdc("event", OFS_EVENT, 32'h3);
    wr(OFS_EVENT, 32'hff);
    $display("t_tx done");
  endtask

  // Two collisions: the first is retried, the second aborts
  task automatic t_abort(input logic [15:0] b1, input logic [15:0] b2, input logic [15:0] size,
                         input logic [31:0] lim, input logic [31:0] exp);
    wr(OFS_RETRY, lim);
    @(posedge pclk);
    tx_desc_size <= size;
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    tx_collision <= 1'b1;
    tx_byte_cnt <= b1;
    @(posedge pclk);
    tx_byte_cnt <= b2;
    #1 chk("tx_retry", 32'h1, {31'h0, tx_retry});
    @(posedge pclk);
    tx_collision <= 1'b0;
    #1 chk("tx_abort", 32'h1, {31'h0, tx_abort});
    chk("tx_stat_wr", 32'h1, {31'h0, tx_stat_wr});
    chk("abort_status", exp, {16'h0, tx_stat_word});
    $display("t_abort done");
  endtask

  // Deferral, underflow retry then abort, bad FCS and length mismatch in one packet
  task automatic t_flags();
    chk("auto_fcs_enable", 32'h1, {31'h0, auto_fcs_enable});
    wr(OFS_CTRL, 32'h0);
    #1 chk("auto_fcs_enable", 32'h0, {31'h0, auto_fcs_enable});
    @(posedge pclk);
    tx_desc_size <= 16'd100;
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    tx_deferring <= 1'b1;
    tx_defer_tick <= 1'b1;
    @(posedge pclk);
    tx_deferring <= 1'b0;
    tx_defer_tick <= 1'b0;
    tx_underflow <= 1'b1;
    tx_underflow_retry <= 1'b1;
    @(posedge pclk);
    tx_underflow_retry <= 1'b0;
    tx_type_len <= 16'd50;
    tx_data_len <= 16'd46;
    tx_fcs_good <= 1'b0;
    #1 chk("tx_retry", 32'h1, {31'h0, tx_retry});
    @(posedge pclk);
    tx_underflow <= 1'b0;
    tx_fcs_good <= 1'b1;
    #1 chk("tx_abort", 32'h1, {31'h0, tx_abort});
    chk("flags_status", 32'h4740, {16'h0, tx_stat_word});
    $display("t_flags done");
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_rx();
    t_tx();
    t_abort(16'h0038, 16'h0039, 16'd1600, 32'hf, 32'h5022);
    t_abort(16'h0010, 16'h0010, 16'd100, 32'h1, 32'h4012);
    t_flags();
    give_verdict();
  end

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule // mac_book_test
